// ---- line_fifo_defines.vh ----
// Constants for the dual clock line FIFO
`ifndef LINE_FIFO_DEFINES_VH
`define LINE_FIFO_DEFINES_VH

// ============================================================
// Storage geometry
`define LF_DEPTH          8192
`define LF_WIDTH          8
`define LF_ADDR_W         13

// ============================================================
// Reset values
`define LF_PTR_RESET      13'h0000
`define LF_DATA_RESET     8'h00

// ============================================================
// Write side pin bundle layout
`define LF_WBUS_W         11
`define LF_WB_CLK         10
`define LF_WB_EN_N        9
`define LF_WB_CLR_N       8
`define LF_WB_DATA_HI     7
`define LF_WB_DATA_LO     0
`define LF_WBUS_RESET     11'h300

// ============================================================
// Fetch side pin bundle layout
`define LF_FBUS_W         3
`define LF_FB_CLK         2
`define LF_FB_EN_N        1
`define LF_FB_CLR_N       0
`define LF_FBUS_RESET     3'h3

// ============================================================
// Timing
`define LF_SYS_CLK_NS     25
`define LF_RETENTION_MS   20
`define LF_RETENTION_CYC  ((`LF_RETENTION_MS * 1000000) / `LF_SYS_CLK_NS)

`endif

// ---- pin_sync.v ----
// Three stage pin synchroniser with agreement filter and one cycle history
`timescale 1ns/1ps

module pin_sync #(
  parameter W          = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] stable_r,
  output reg  [W-1:0] prev_r
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer     i;

  // ============================================================
  // Synchroniser chain and filter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r     <= INIT;
      s2_r     <= INIT;
      s3_r     <= INIT;
      stable_r <= INIT;
      prev_r   <= INIT;
    end else begin
      s1_r   <= pin_in;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      prev_r <= stable_r;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          stable_r[i] <= s3_r[i];
        end
      end
    end
  end

endmodule // pin_sync

// ---- line_pointer.v ----
// Wrapping location pointer with clear and advance
`timescale 1ns/1ps
`include "line_fifo_defines.vh"

module line_pointer #(
  parameter DEPTH  = `LF_DEPTH,
  parameter ADDR_W = `LF_ADDR_W
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire              port_edge,
  input  wire              enable_n,
  input  wire              clear_n,
  output reg  [ADDR_W-1:0] ptr_r
);

  localparam [31:0]       LAST_I = DEPTH - 1;
  localparam [ADDR_W-1:0] LAST   = LAST_I[ADDR_W-1:0];
  localparam [ADDR_W-1:0] ZERO   = {ADDR_W{1'b0}};

  reg [ADDR_W-1:0] ptr_nxt;

  // ============================================================
  // Next location with wrap
  function [ADDR_W-1:0] next_loc;
    input [ADDR_W-1:0] cur;
    begin
      if (cur == LAST) begin
        next_loc = {ADDR_W{1'b0}};
      end else begin
        next_loc = cur + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  always @* begin
    ptr_nxt = ptr_r;
    if (port_edge) begin
      if (!clear_n) begin
        ptr_nxt = ZERO;
      end else if (!enable_n) begin
        ptr_nxt = next_loc(ptr_r);
      end
    end
  end

  // ============================================================
  // Pointer register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= ZERO;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

endmodule // line_pointer

// ---- dual_clock_line_fifo.v ----
// Line buffer with independent write and fetch ports
`timescale 1ns/1ps
`include "line_fifo_defines.vh"

// Function
// - 8192 by 8 storage, first in first out
// - Write and fetch ports fully independent
// - Enabled write edge without clear stores input word
// - Stored word advances write pointer
// - Disabled write stores nothing, holds pointer unless cleared
// - Write clear returns pointer to start
// - Enabled fetch edge without clear outputs pointed word
// - Output word advances fetch pointer
// - Disabled fetch outputs no word, holds pointer unless cleared
// - Disabled fetch drops FETCH_DATA_OE to float data outputs
// - Fetch clear returns pointer to start
module dual_clock_line_fifo #(
  parameter DEPTH  = `LF_DEPTH,
  parameter WIDTH  = `LF_WIDTH,
  parameter ADDR_W = `LF_ADDR_W
) (
  input  wire             SYS_CLK,
  input  wire             RESETN,
  input  wire             WRITE_CLOCK,
  input  wire             WRITE_ENABLE_N,
  input  wire             WRITE_POINTER_CLEAR_N,
  input  wire [WIDTH-1:0] WRITE_DATA_IN,
  input  wire             FETCH_CLOCK,
  input  wire             FETCH_ENABLE_N,
  input  wire             FETCH_POINTER_CLEAR_N,
  output reg  [WIDTH-1:0] FETCH_DATA_OUT,
  output reg              FETCH_DATA_OE
);

  // ============================================================
  // Reset release
  reg rst_s1_r;
  reg rst_s2_r;

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  wire rst_n = rst_s2_r;

  // ============================================================
  // Pin synchronisers
  wire [`LF_WBUS_W-1:0] wbus_stable;
  wire [`LF_WBUS_W-1:0] wbus_prev;
  wire [`LF_FBUS_W-1:0] fbus_stable;
  wire [`LF_FBUS_W-1:0] fbus_prev;

  pin_sync #(
    .W    (`LF_WBUS_W),
    .INIT (`LF_WBUS_RESET)
  ) u_write_sync (
    .clk      (SYS_CLK),
    .rst_n    (rst_n),
    .pin_in   ({WRITE_CLOCK, WRITE_ENABLE_N, WRITE_POINTER_CLEAR_N, WRITE_DATA_IN}),
    .stable_r (wbus_stable),
    .prev_r   (wbus_prev)
  );

  pin_sync #(
    .W    (`LF_FBUS_W),
    .INIT (`LF_FBUS_RESET)
  ) u_fetch_sync (
    .clk      (SYS_CLK),
    .rst_n    (rst_n),
    .pin_in   ({FETCH_CLOCK, FETCH_ENABLE_N, FETCH_POINTER_CLEAR_N}),
    .stable_r (fbus_stable),
    .prev_r   (fbus_prev)
  );

  // ============================================================
  // Port edges, values held just before each edge, and current fetch enable
  wire             write_edge = wbus_stable[`LF_WB_CLK] & ~wbus_prev[`LF_WB_CLK];
  wire             write_en_n = wbus_prev[`LF_WB_EN_N];
  wire             write_clr_n = wbus_prev[`LF_WB_CLR_N];
  wire [WIDTH-1:0] write_word = wbus_prev[`LF_WB_DATA_HI:`LF_WB_DATA_LO];
  wire             fetch_edge = fbus_stable[`LF_FB_CLK] & ~fbus_prev[`LF_FB_CLK];
  wire             fetch_en_n = fbus_prev[`LF_FB_EN_N];
  wire             fetch_clr_n = fbus_prev[`LF_FB_CLR_N];
  wire             fetch_en_n_now = fbus_stable[`LF_FB_EN_N];

  // ============================================================
  // Pointers
  wire [ADDR_W-1:0] write_ptr;
  wire [ADDR_W-1:0] fetch_ptr;

  line_pointer #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W)
  ) u_write_ptr (
    .clk       (SYS_CLK),
    .rst_n     (rst_n),
    .port_edge (write_edge),
    .enable_n  (write_en_n),
    .clear_n   (write_clr_n),
    .ptr_r     (write_ptr)
  );

  line_pointer #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W)
  ) u_fetch_ptr (
    .clk       (SYS_CLK),
    .rst_n     (rst_n),
    .port_edge (fetch_edge),
    .enable_n  (fetch_en_n),
    .clear_n   (fetch_clr_n),
    .ptr_r     (fetch_ptr)
  );

  // ============================================================
  // Storage
  // line storage array
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];

  wire do_write = write_edge & ~write_en_n & write_clr_n;
  wire do_fetch = fetch_edge & ~fetch_en_n & fetch_clr_n;

  always @(posedge SYS_CLK) begin
    if (do_write) begin
      mem_r[write_ptr] <= write_word;
    end
  end

  // ============================================================
  // Fetch output
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      FETCH_DATA_OUT <= `LF_DATA_RESET;
      FETCH_DATA_OE  <= 1'b0;
    end else begin
      if (do_fetch) begin
        FETCH_DATA_OUT <= mem_r[fetch_ptr];
      end
      FETCH_DATA_OE <= ~fetch_en_n_now;
    end
  end

endmodule // dual_clock_line_fifo

// ---- line_fifo_properties.sv ----
// Fetch port checker for the line FIFO
`timescale 1ns/1ps
module line_fifo_checker (
  input wire       SYS_CLK,
  input wire       RESETN,
  input wire       FETCH_CLOCK,
  input wire       FETCH_ENABLE_N,
  input wire       FETCH_POINTER_CLEAR_N,
  input wire [7:0] FETCH_DATA_OUT,
  input wire       FETCH_DATA_OE
);
  // ====
  // Properties
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  property p_oe_on; $fell(FETCH_ENABLE_N) ##1 !FETCH_ENABLE_N [*7] |-> FETCH_DATA_OE; endproperty
  property p_oe_off; $rose(FETCH_ENABLE_N) ##1 FETCH_ENABLE_N [*7] |-> !FETCH_DATA_OE; endproperty
  property p_idle; FETCH_ENABLE_N [*8] |=> $stable(FETCH_DATA_OUT); endproperty
  property p_gap; $changed(FETCH_DATA_OUT) |=> $stable(FETCH_DATA_OUT) [*5]; endproperty
  property p_rise; $rose(FETCH_CLOCK) |-> $stable(FETCH_DATA_OUT) [*3]; endproperty
  property p_off; $rose(FETCH_CLOCK) && FETCH_ENABLE_N |=> $stable(FETCH_DATA_OUT) [*7]; endproperty
  property p_clr; $rose(FETCH_CLOCK) && !FETCH_POINTER_CLEAR_N |=> $stable(FETCH_DATA_OUT) [*7]; endproperty
  property p_drive; $changed(FETCH_DATA_OUT) |-> FETCH_DATA_OE; endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe late");
  a_oe_off: assert property (p_oe_off) else $error("oe stuck");
  a_idle: assert property (p_idle) else $error("idle change");
  a_gap: assert property (p_gap) else $error("fast change");
  a_rise: assert property (p_rise) else $error("early data");
  a_off: assert property (p_off) else $error("off fetch");
  a_clr: assert property (p_clr) else $error("clear fetch");
  a_drive: assert property (p_drive) else $error("hidden data");
  c_fetch: cover property ($changed(FETCH_DATA_OUT));
  c_float: cover property ($fell(FETCH_DATA_OE));
  c_clear: cover property ($rose(FETCH_CLOCK) && !FETCH_POINTER_CLEAR_N);
endmodule // line_fifo_checker
bind dual_clock_line_fifo line_fifo_checker chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .FETCH_CLOCK(FETCH_CLOCK),
  .FETCH_ENABLE_N(FETCH_ENABLE_N), .FETCH_POINTER_CLEAR_N(FETCH_POINTER_CLEAR_N),
  .FETCH_DATA_OUT(FETCH_DATA_OUT), .FETCH_DATA_OE(FETCH_DATA_OE));

// ---- line_fifo_partner.sv ----
// Producer and consumer model for the line FIFO pins
`timescale 1ns/1ps
module line_fifo_partner (
  input  wire       clk,
  input  wire       oe,
  input  wire [7:0] dout,
  output reg        write_clock = 1'h0,
  output reg        we_n = 1'h1,
  output reg        wclr_n = 1'h1,
  output reg  [7:0] wd = 8'h00,
  output reg        fck = 1'h0,
  output reg        re_n = 1'h1,
  output reg        rclr_n = 1'h1
);
  // ====
  // Port cycles
  // steady short cycles
  task wr(input [7:0] d, input en_n, input clr_n);
    begin
      @(posedge clk);
      wd <= d;
      we_n <= en_n;
      wclr_n <= clr_n;
      repeat (4) @(posedge clk);
      write_clock <= 1'h1;
      repeat (5) @(posedge clk);
      write_clock <= 1'h0;
      wd <= ~d;
      we_n <= 1'h1;
      wclr_n <= 1'h1;
    end
  endtask
  task rd(input en_n, input clr_n, output [7:0] q);
    begin
      @(posedge clk);
      re_n <= en_n;
      rclr_n <= clr_n;
      repeat (4) @(posedge clk);
      fck <= 1'h1;
      repeat (9) @(posedge clk);
      @(negedge clk);
      q = oe ? dout : 8'hZZ;
      @(posedge clk);
      fck <= 1'h0;
      rclr_n <= 1'h1;
    end
  endtask
endmodule // line_fifo_partner

// ---- dual_clock_line_fifo_tb.sv ----
// Self-checking bench for the line FIFO
`timescale 1ns/1ps
module dual_clock_line_fifo_tb;
  reg        sys_clk = 1'h0;
  reg        resetn = 1'h0;
  reg  [7:0] q;
  integer    mismatches = 0;
  integer    checked = 0;
  integer    cycles = 0;
  integer    i;
  wire       write_clock, we_n, wclr_n, fck, re_n, rclr_n, oe;
  wire [7:0] wd, dout;
  always #12.5 sys_clk = ~sys_clk;
  line_fifo_partner far (.clk(sys_clk), .oe(oe), .dout(dout), .write_clock(write_clock), .we_n(we_n), .wclr_n(wclr_n),
    .wd(wd), .fck(fck), .re_n(re_n), .rclr_n(rclr_n));
  dual_clock_line_fifo #(.DEPTH(16), .ADDR_W(4)) dut (.SYS_CLK(sys_clk), .RESETN(resetn), .WRITE_CLOCK(write_clock),
    .WRITE_ENABLE_N(we_n), .WRITE_POINTER_CLEAR_N(wclr_n), .WRITE_DATA_IN(wd), .FETCH_CLOCK(fck),
    .FETCH_ENABLE_N(re_n), .FETCH_POINTER_CLEAR_N(rclr_n), .FETCH_DATA_OUT(dout), .FETCH_DATA_OE(oe));
  // ====
  // Scenarios
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task fe(input en_n, input [7:0] exp);
    begin
      far.rd(en_n, 1'h1, q);
      chk(q, exp);
    end
  endtask
  task t_order;
    begin
      far.wr(8'h00, 1'h1, 1'h0);
      far.rd(1'h1, 1'h0, q);
      far.wr(8'hA0, 1'h0, 1'h1);
      far.wr(8'h55, 1'h1, 1'h1);
      far.wr(8'hA1, 1'h0, 1'h1);
      far.wr(8'hA2, 1'h0, 1'h1);
      fork
        far.wr(8'hB0, 1'h0, 1'h1);
        begin
          fe(1'h0, 8'hA0);
          fe(1'h0, 8'hA1);
          fe(1'h1, 8'hZZ);
          fe(1'h0, 8'hA2);
        end
      join
    end
  endtask
  task t_clear;
    begin
      far.wr(8'hC0, 1'h0, 1'h0);
      far.wr(8'hC1, 1'h0, 1'h1);
      far.wr(8'hC2, 1'h0, 1'h1);
      far.rd(1'h0, 1'h0, q);
      fe(1'h0, 8'hC1);
      fe(1'h0, 8'hC2);
      fe(1'h0, 8'hA2);
    end
  endtask
  task t_wrap;
    begin
      far.wr(8'h00, 1'h1, 1'h0);
      far.rd(1'h1, 1'h0, q);
      for (i = 0; i < 17; i = i + 1) far.wr(8'h40 + i[7:0], 1'h0, 1'h1);
      for (i = 0; i < 17; i = i + 1) fe(1'h0, (i % 16 == 0) ? 8'h50 : 8'h40 + i[7:0]);
    end
  endtask
  task finish_test;
    begin
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'h1;
    repeat (4) @(posedge sys_clk);
    t_order;
    t_clear;
    t_wrap;
    finish_test;
  end
endmodule // dual_clock_line_fifo_tb
